// [design/hss_defines.vh]
// Constants for the dual-channel switch fault logic and converter scheduler.
// Assumes inclusion by bare name from the design files.
`ifndef HSS_DEFINES_VH
`define HSS_DEFINES_VH
// Charge mode encodings
`define HSS_CHRG_NONE 2'h0
`define HSS_CHRG_REG 2'h2
// Source indices, in round-robin order
`define HSS_SRC_I1 4'h0
`define HSS_SRC_I2 4'h1
`define HSS_SRC_T1 4'h2
`define HSS_SRC_T2 4'h3
`define HSS_SRC_VBB 4'h4
`define HSS_SRC_V1 4'h5
`define HSS_SRC_V2 4'h6
`define HSS_SRC_DS1 4'h7
`define HSS_SRC_DS2 4'h8
`define HSS_SRC_LAST 4'h8
`define HSS_NUM_SRC 9
// Result width
`define HSS_RES_W 10
// Delay after each full sequence outside current-only mode, in cycles, per sample_delay_select code
`define HSS_DLY_0 16'h0000
`define HSS_DLY_1 16'h00ff
`define HSS_DLY_2 16'h0fff
`define HSS_DLY_3 16'hffff
// Channel fault states
`define HSS_CH_OFF 2'h0
`define HSS_CH_INRUSH 2'h1
`define HSS_CH_ON 2'h2
`define HSS_CH_WAIT 2'h3
`endif

// [design/hss_channel.v]
// Per-channel fault response: retry, latch-off, thermal and reverse battery.
// Assumes fault flags and the retry timer strobe come from the analog front end.
`timescale 1ns/1ps
`default_nettype none
`include "hss_defines.vh"
module hss_channel (
    input wire clk,
    input wire rst_n,
    input wire channel_on_command,
    input wire direct_input_pin,
    input wire fault_latch_select,
    input wire [1:0] charge_mode_select,
    input wire inrush_configured,
    input wire inrush_done,
    input wire short_detect,
    input wire overcurrent_trip,
    input wire rel_temp_over,
    input wire abs_temp_over,
    input wire retry_timer_expired,
    input wire reverse_battery,
    output reg switch_on,
    output reg inrush_active,
    output reg latched_off,
    output reg thermal_fault
);
    localparam ST_OFF = `HSS_CH_OFF;
    localparam ST_INRUSH = `HSS_CH_INRUSH;
    localparam ST_ON = `HSS_CH_ON;
    localparam ST_WAIT = `HSS_CH_WAIT;
    reg [1:0] state;
    reg [1:0] next_state;
    reg next_latched;
    reg prev_cmd;
    reg prev_pin;
    reg prev_latch_sel;
    wire request = channel_on_command | direct_input_pin;
    wire toggle = (channel_on_command ^ prev_cmd) | (direct_input_pin ^ prev_pin);
    wire latch_toggle = fault_latch_select ^ prev_latch_sel;
    wire therm = rel_temp_over | abs_temp_over;
    wire oc_fault = overcurrent_trip | (short_detect && charge_mode_select == `HSS_CHRG_REG);
    // Never start into a live thermal fault; the channel waits for it to clear
    wire [1:0] start_st = therm ? ST_OFF : (inrush_configured ? ST_INRUSH : ST_ON);

    always @* begin
        next_state = state;
        next_latched = latched_off;
        if (latched_off && (toggle || latch_toggle)) begin
            next_latched = 1'b0;
            next_state = request ? start_st : ST_OFF;
        end else if (latched_off) begin
            next_state = ST_OFF;
        end else if (!request) begin
            next_state = ST_OFF;
        end else begin
            case (state)
                ST_OFF: begin
                    next_state = start_st;
                end
                ST_INRUSH, ST_ON: begin
                    if (therm || oc_fault) begin
                        if (fault_latch_select) begin
                            next_latched = 1'b1;
                            next_state = ST_OFF;
                        end else begin
                            next_state = ST_WAIT;
                        end
                    end else if (state == ST_INRUSH && inrush_done) begin
                        next_state = ST_ON;
                    end
                end
                ST_WAIT: begin
                    if (retry_timer_expired && !therm) begin
                        next_state = start_st;
                    end
                end
                default: begin
                    next_state = ST_OFF;
                end
            endcase
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_OFF;
            latched_off <= 1'b0;
            prev_cmd <= 1'b0;
            prev_pin <= 1'b0;
            prev_latch_sel <= 1'b0;
            switch_on <= 1'b0;
            inrush_active <= 1'b0;
            thermal_fault <= 1'b0;
        end else begin
            state <= next_state;
            latched_off <= next_latched;
            prev_cmd <= channel_on_command;
            prev_pin <= direct_input_pin;
            prev_latch_sel <= fault_latch_select;
            // Reverse battery forces conduction to spare the body diode
            switch_on <= reverse_battery |
                ((next_state == ST_INRUSH) || (next_state == ST_ON));
            inrush_active <= (next_state == ST_INRUSH) && !reverse_battery;
            thermal_fault <= therm;
        end
    end
endmodule
`default_nettype wire

// [design/hss_core.v]
// Dual-channel fault logic plus the shared converter's round-robin scheduler.
// Assumes the converter handshakes with start/done and all inputs are synchronous.
`timescale 1ns/1ps
`default_nettype none
`include "hss_defines.vh"
module hss_core (
    input wire clk,
    input wire rst_n,
    input wire [1:0] channel_on_command,
    input wire [1:0] direct_input_pin,
    input wire [1:0] fault_latch_select,
    input wire [3:0] charge_mode_select,
    input wire [7:0] inrush_current_limit,
    input wire [1:0] inrush_configured,
    input wire [1:0] inrush_done,
    input wire [1:0] short_detect,
    input wire [1:0] overcurrent_trip,
    input wire [1:0] rel_temp_over,
    input wire [1:0] abs_temp_over,
    input wire [1:0] retry_timer_expired,
    input wire reverse_battery,
    output wire [1:0] switch_on,
    output wire [1:0] inrush_active,
    output wire [1:0] latched_off,
    output wire [1:0] thermal_fault,
    output reg [7:0] regulated_current_limit,
    input wire global_current_sense_off,
    input wire global_temp_sense_off,
    input wire global_supply_sense_off,
    input wire global_output_sense_off,
    input wire global_drain_source_off,
    input wire [1:0] chan_current_sense_off,
    input wire [1:0] chan_output_sense_off,
    input wire [1:0] chan_drain_source_off,
    input wire [1:0] sample_delay_select,
    input wire [1:0] wire_heat_protect_enable,
    input wire [1:0] wire_heat_protect_active,
    output reg conv_start,
    output reg [3:0] conv_source,
    output reg current_sense_power,
    input wire conv_done,
    input wire [9:0] conv_result,
    input wire [3:0] read_select,
    input wire read_strobe,
    output reg [9:0] read_data,
    output reg [8:0] result_fresh
);
    localparam SC_PICK = 2'h0;
    localparam SC_CONV = 2'h1;
    localparam SC_DELAY = 2'h2;
    reg [1:0] sc_state;
    reg [15:0] delay_cnt;
    reg [9:0] result_mem [0:8];
    reg [8:0] src_en;
    reg [3:0] next_src;
    reg wrap;
    reg found;
    integer i;
    integer k;

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_ch
            hss_channel u_ch (
                .clk(clk),
                .rst_n(rst_n),
                .channel_on_command(channel_on_command[g]),
                .direct_input_pin(direct_input_pin[g]),
                .fault_latch_select(fault_latch_select[g]),
                .charge_mode_select(charge_mode_select[2*g+1:2*g]),
                .inrush_configured(inrush_configured[g]),
                .inrush_done(inrush_done[g]),
                .short_detect(short_detect[g]),
                .overcurrent_trip(overcurrent_trip[g]),
                .rel_temp_over(rel_temp_over[g]),
                .abs_temp_over(abs_temp_over[g]),
                .retry_timer_expired(retry_timer_expired[g]),
                .reverse_battery(reverse_battery),
                .switch_on(switch_on[g]),
                .inrush_active(inrush_active[g]),
                .latched_off(latched_off[g]),
                .thermal_fault(thermal_fault[g])
            );
        end
    endgenerate

    // Inrush regulation level follows the one limit field shared by both channels
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            regulated_current_limit <= 8'h00;
        end else begin
            regulated_current_limit <= inrush_current_limit;
        end
    end

    wire heat_mode = |(wire_heat_protect_enable & wire_heat_protect_active);

    // Enabled sources; level based so suppression lifts on its own
    always @* begin
        src_en[0] = !global_current_sense_off && !chan_current_sense_off[0];
        src_en[1] = !global_current_sense_off && !chan_current_sense_off[1];
        src_en[2] = !global_temp_sense_off && !heat_mode;
        src_en[3] = !global_temp_sense_off && !heat_mode;
        src_en[4] = !global_supply_sense_off && !heat_mode;
        src_en[5] = !global_output_sense_off && !chan_output_sense_off[0] && !heat_mode;
        src_en[6] = !global_output_sense_off && !chan_output_sense_off[1] && !heat_mode;
        src_en[7] = !global_drain_source_off && !chan_drain_source_off[0] && !heat_mode;
        src_en[8] = !global_drain_source_off && !chan_drain_source_off[1] && !heat_mode;
    end

    // Next enabled source after the current one; wrap marks end of a pass
    always @* begin
        next_src = conv_source;
        wrap = 1'b0;
        found = 1'b0;
        for (i = 1; i <= `HSS_NUM_SRC; i = i + 1) begin
            k = (conv_source + i) % `HSS_NUM_SRC;
            if (!found && src_en[k]) begin
                found = 1'b1;
                next_src = k[3:0];
                wrap = (k <= conv_source);
            end
        end
    end

    function [15:0] delay_of;
        input [1:0] sel;
        begin
            case (sel)
                2'h0: delay_of = `HSS_DLY_0;
                2'h1: delay_of = `HSS_DLY_1;
                2'h2: delay_of = `HSS_DLY_2;
                default: delay_of = `HSS_DLY_3;
            endcase
        end
    endfunction

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sc_state <= SC_PICK;
            conv_source <= `HSS_SRC_LAST;
            conv_start <= 1'b0;
            current_sense_power <= 1'b0;
            delay_cnt <= 16'h0000;
        end else begin
            conv_start <= 1'b0;
            case (sc_state)
                SC_PICK: begin
                    if (found) begin
                        conv_source <= next_src;
                        conv_start <= 1'b1;
                        current_sense_power <= (next_src <= `HSS_SRC_I2);
                        sc_state <= SC_CONV;
                    end
                end
                SC_CONV: begin
                    if (conv_done) begin
                        current_sense_power <= 1'b0;
                        // Delay only after a full pass, never in current-only mode
                        if (wrap && !heat_mode && sample_delay_select != 2'h0) begin
                            delay_cnt <= delay_of(sample_delay_select);
                            sc_state <= SC_DELAY;
                        end else begin
                            sc_state <= SC_PICK;
                        end
                    end
                end
                SC_DELAY: begin
                    if (heat_mode || delay_cnt == 16'h0000) begin
                        sc_state <= SC_PICK;
                    end else begin
                        delay_cnt <= delay_cnt - 16'h0001;
                    end
                end
                default: begin
                    sc_state <= SC_PICK;
                end
            endcase
        end
    end

    // Result store; results live in a flop array, read data registered
    always @(posedge clk) begin
        if (sc_state == SC_CONV && conv_done) begin
            result_mem[conv_source] <= conv_result;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            read_data <= 10'h000;
            result_fresh <= 9'h000;
        end else begin
            if (read_strobe && read_select <= `HSS_SRC_LAST) begin
                read_data <= result_mem[read_select];
                result_fresh[read_select] <= 1'b0;
            end
            // A store in the same cycle as a read keeps the flag set
            if (sc_state == SC_CONV && conv_done) begin
                result_fresh[conv_source] <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// [dv/hss_adc_model.sv]
// Converter stand-in: one done pulse with a result per start, lat+1 cycles later.
// Assumes at most one start in flight, as the scheduler promises.
`timescale 1ns/1ps
`default_nettype none
module hss_adc_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] lat,
    input wire logic conv_start,
    input wire logic [3:0] conv_source,
    output logic conv_done,
    output logic [9:0] conv_result
);
    logic [7:0] cnt;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 8'h00;
            conv_done <= 1'b0;
            conv_result <= 10'h000;
        end else begin
            conv_done <= (cnt == 8'h01);
            // Result lines carry junk outside the done cycle
            conv_result <= (cnt == 8'h01) ? {6'h2c, conv_source} : ~conv_result;
            if (conv_start)
                cnt <= lat;
            else if (cnt != 8'h00)
                cnt <= cnt - 8'h01;
        end
    end
endmodule
`default_nettype wire

// [dv/hss_core_sva.sv]
// Checks on hss_core outputs against their causes at its inputs.
// Assumes it is bound to hss_core and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module hss_core_sva (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [1:0] rel_temp_over,
    input wire logic [1:0] abs_temp_over,
    input wire logic reverse_battery,
    input wire logic [1:0] switch_on,
    input wire logic [1:0] thermal_fault,
    input wire logic [1:0] wire_heat_protect_enable,
    input wire logic [1:0] wire_heat_protect_active,
    input wire logic global_current_sense_off,
    input wire logic conv_start,
    input wire logic [3:0] conv_source,
    input wire logic current_sense_power,
    input wire logic conv_done,
    input wire logic [8:0] result_fresh
);
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    wire logic heat = |(wire_heat_protect_enable & wire_heat_protect_active);
    a_start_pulse: assert property (conv_start |=> !conv_start)
        else $error("start pulse too long");
    a_power_match: assert property (conv_start
        |-> current_sense_power == (conv_source < 4'h2))
        else $error("sense power wrong at start");
    a_power_only: assert property (current_sense_power |-> conv_source < 4'h2)
        else $error("sense power on for other source");
    a_heat_isns: assert property (heat [*3] ##0 conv_start |-> conv_source < 4'h2)
        else $error("non current source in heat mode");
    a_heat_nodelay: assert property ((conv_done && heat && !global_current_sense_off)
        ##1 heat [*2] |-> conv_start)
        else $error("delay seen in heat mode");
    a_fresh_set: assert property (conv_done |=> result_fresh[$past(conv_source)])
        else $error("fresh flag not set");
    a_thermal_off: assert property ((rel_temp_over[0] | abs_temp_over[0])
        && !reverse_battery |=> !switch_on[0] && thermal_fault[0])
        else $error("thermal fault left switch on");
    a_rev_on: assert property (reverse_battery |=> switch_on == 2'h3)
        else $error("reverse battery did not force on");
endmodule
bind hss_core hss_core_sva u_sva (.clk, .rst_n, .rel_temp_over, .abs_temp_over, .reverse_battery,
    .switch_on, .thermal_fault, .wire_heat_protect_enable, .wire_heat_protect_active,
    .global_current_sense_off, .conv_start, .conv_source, .current_sense_power, .conv_done,
    .result_fresh);
`default_nettype wire

// [dv/tb_hss_core.sv]
// Self-checking bench for hss_core with a behavioural converter.
// Assumes a 40 MHz clock; inputs change 2 ns after each rising edge.
`timescale 1ns/1ps
`default_nettype none
module tb_hss_core;
    logic clk, rst_n, rev, stb, g_i, g_t, g_s, g_o, g_d, done, start, pwr;
    logic [1:0] cmd, pin, lsel, icfg, idn, sht, oc, rel, abst, rty, c_o, c_d, dly, hen, hact;
    logic [1:0] sw, inr, lch, thf, c_i;
    logic [3:0] cms, src, rsel;
    logic [7:0] ilim, rlim, mlat;
    logic [9:0] res, rdata;
    logic [8:0] fresh;
    logic [3:0] q[$];
    int error_cnt, cmp_count, i;
    hss_core u_hss_core (.clk(clk), .rst_n(rst_n), .channel_on_command(cmd),
        .direct_input_pin(pin), .fault_latch_select(lsel), .charge_mode_select(cms),
        .inrush_current_limit(ilim), .inrush_configured(icfg), .inrush_done(idn),
        .short_detect(sht), .overcurrent_trip(oc), .rel_temp_over(rel), .abs_temp_over(abst),
        .retry_timer_expired(rty), .reverse_battery(rev), .switch_on(sw), .inrush_active(inr),
        .latched_off(lch), .thermal_fault(thf), .regulated_current_limit(rlim),
        .global_current_sense_off(g_i), .global_temp_sense_off(g_t),
        .global_supply_sense_off(g_s), .global_output_sense_off(g_o),
        .global_drain_source_off(g_d), .chan_current_sense_off(c_i),
        .chan_output_sense_off(c_o), .chan_drain_source_off(c_d), .sample_delay_select(dly),
        .wire_heat_protect_enable(hen), .wire_heat_protect_active(hact), .conv_start(start),
        .conv_source(src), .current_sense_power(pwr), .conv_done(done), .conv_result(res),
        .read_select(rsel), .read_strobe(stb), .read_data(rdata), .result_fresh(fresh));
    hss_adc_model u_hss_adc_model (.clk(clk), .rst_n(rst_n), .lat(mlat), .conv_start(start),
        .conv_source(src), .conv_done(done), .conv_result(res));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) if (start) q.push_back(src);
    task step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task results;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Collect enough starts to hold a whole pass, then align on source 0
    task seq(input int n, input logic [35:0] exp, input int bound);
        int k, j;
        q.delete();
        k = 0;
        while (q.size() < 2 * n + 9 && k < bound) begin
            step(1);
            k++;
        end
        if (k >= bound) begin
            error_cnt++;
            results();
        end else begin
            j = 0;
            while (j < 9 && q[j] !== 4'h0) j++;
            for (k = 0; k < n; k++) chk({12'h000, q[j + k]}, {12'h000, exp[4 * k +: 4]});
            $display("sequence test done");
        end
    endtask
    task rd(input logic [3:0] s, input logic [9:0] exp);
        rsel = s;
        stb = 1'b1;
        step(1);
        stb = 1'b0;
        chk({6'h00, rdata}, {6'h00, exp});
        // Let an edge pass so a following read never re-raises the strobe at once
        step(1);
    endtask
    task pulse(input logic [1:0] dn, input logic [1:0] sh, input logic [1:0] o,
        input logic [1:0] r);
        {idn, sht, oc, rty} = {dn, sh, o, r};
        step(1);
        {idn, sht, oc, rty} = 8'h00;
        step(2);
    endtask
    initial begin
        {rst_n, rev, stb, g_i, g_t, g_s, g_o, g_d} = 8'h00;
        {cmd, pin, lsel, idn, sht, oc, rel, abst, rty, c_o, c_d, dly, hen, hact} = 28'h0;
        {cms, rsel, ilim, icfg, mlat} = {4'ha, 4'h0, 8'h5a, 2'h3, 8'h03};
        c_i = 2'b00;
        step(5);
        chk({sw, inr, lch, thf, src}, 16'h0008);
        rst_n = 1'b1;
        seq(9, 36'h876543210, 400);
        hen = 2'b11;
        seq(9, 36'h876543210, 400);
        {g_t, c_o, mlat} = {1'b1, 2'b01, 8'h06};
        seq(6, 36'h876410, 700);
        c_i = 2'b10;
        seq(5, 36'h87640, 700);
        {g_t, c_o, c_i, mlat, dly, hact} = {1'b0, 2'b00, 2'b00, 8'h01, 2'h3, 2'b10};
        seq(4, 36'h1010, 300);
        {dly, hact} = 4'h0;
        seq(9, 36'h876543210, 400);
        dly = 2'h1;
        q.delete();
        i = 0;
        while (q.size() < 19 && i < 3000) begin
            step(1);
            i++;
        end
        chk(i >= 511 && i < 3000, 1);
        if (i >= 3000)
            results();
        $display("delay test done");
        dly = 2'h0;
        {g_i, g_t, g_s, g_o, g_d} = 5'h1f;
        step(40);
        chk(fresh[4], 1);
        rd(4'h4, 10'h2c4);
        chk(fresh[4], 0);
        rd(4'h9, 10'h2c4);
        $display("read test done");
        cmd = 2'b01;
        step(3);
        chk({inr[0], sw[0], rlim}, 10'h35a);
        // Outside regulation mode a one-cycle short is not a fault
        cms = 4'h8;
        pulse(0, 1, 0, 0);
        chk(sw[0], 1);
        cms = 4'ha;
        pulse(1, 0, 0, 0);
        pulse(0, 1, 0, 0);
        chk(sw[0], 0);
        pulse(0, 0, 0, 1);
        chk({inr[0], sw[0]}, 2'b11);
        lsel = 2'b01;
        pulse(1, 0, 0, 0);
        pulse(0, 0, 1, 0);
        pulse(0, 0, 0, 1);
        chk({lch[0], sw[0]}, 2'b10);
        cmd = 2'b00;
        step(2);
        cmd = 2'b01;
        step(3);
        chk({lch[0], inr[0], sw[0]}, 3'b011);
        pulse(1, 0, 1, 0);
        lsel = 2'b00;
        step(1);
        lsel = 2'b01;
        step(3);
        chk({lch[0], inr[0], sw[0]}, 3'b011);
        pin = 2'b10;
        pulse(3, 0, 0, 0);
        rel = 2'b01;
        step(3);
        chk({thf[0], sw}, 3'b110);
        {rel, abst} = 4'b0010;
        step(3);
        chk(sw[1], 0);
        {abst, cmd, pin, rev} = 7'h01;
        step(3);
        chk(sw, 2'b11);
        rev = 1'b0;
        $display("channel test done");
        results();
    end
endmodule
`default_nettype wire
